// ==== logic/spirp_pkg.sv ====
// Package: constants shared by the serial register read port.
// Assumes a register file outside that answers a read address within one mclk cycle.
package spirp_pkg;

  // Link bit counter figures (rising edges of the serial clock)
  localparam logic [4:0] CNT_IDLE       = 5'h00; // Counter value at frame start
  localparam logic [4:0] CNT_ADDR_LAST  = 5'h07; // Edge before last address bit lands
  localparam logic [4:0] CNT_DUMMY_LAST = 5'h10; // Pulse 16, end of don't-care byte
  localparam logic [4:0] CNT_BYTE_FIRST = 5'h11; // Pulse 17, first data bit
  localparam logic [4:0] CNT_BYTE_LAST  = 5'h18; // Pulse 24, last data bit

  // Reset values
  localparam logic [6:0] ADDR_RST = 7'h00; // Register address after reset
  localparam logic [7:0] DATA_RST = 8'h00; // Data words after reset
  localparam logic       MODE_RST = 1'b0;  // Four-wire mode after reset

  // Fetch state machine on the system clock
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01, // Waiting for a link request
    ST_FETCH = 2'b10  // Capturing register data
  } spirp_state_t;

endpackage : spirp_pkg

// ==== logic/spirp_read_port.sv ====
// Serial register read port: link side on the serial clock, fetch side on mclk.
// Assumes a combinational register file read on reg_addr / reg_data in the mclk domain.
// Function
// - Seven address bits select first register.
// - Four-wire: data out pulses 17-24, MSB first.
// - Continued clocking increments address every byte.
// - Three-wire: shared data pin carries both directions.
// - Three-wire read keeps the write framing.
// - Turn pin around at falling edge 16.
// - Mode 00: rise samples, fall drives.
// - Three-wire keeps serial out driver off.
// - Reset selects four-wire mode; three_wire_select replaces it at the next enabled mclk.
// - Secondary only, never starts a transaction.
`timescale 1ns/1ps
`default_nettype none
module spirp_read_port (
  // System clock and control
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       three_wire_select,
  // Register file read
  output logic [6:0]      reg_addr,
  input  wire logic [7:0] reg_data,
  // Serial link pins
  input  wire logic       sclk,
  input  wire logic       chip_select_n,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  output logic            serial_out_oe_n,
  output logic            shared_data_out,
  output logic            shared_data_oe_n
);

  // ---------------- System clock side ----------------
  logic                  mode;           // Three-wire selected
  logic                  next_mode;
  logic                  req_s1;         // Request toggle synchroniser stage 1
  logic                  req_s2;         // Stage 2
  logic                  req_s3;         // Edge detect history
  logic [7:0]            hold;           // Fetched byte for the link
  logic [7:0]            next_hold;
  logic [6:0]            next_reg_addr;
  spirp_pkg::spirp_state_t state;        // Fetch state
  spirp_pkg::spirp_state_t next_state;
  logic                  req_edge;       // New request seen

  // ---------------- Link side ----------------
  logic [4:0]            cnt;            // Rising edge count in frame
  logic [4:0]            next_cnt;
  logic                  rw;             // Read flag from first bit
  logic                  next_rw;
  logic [6:0]            link_addr;      // Address being read
  logic [6:0]            next_link_addr;
  logic                  req;            // Fetch request toggle
  logic                  next_req;
  logic                  mode_s1;        // Mode synchroniser stage 1
  logic                  mode_s2;        // Mode synchroniser stage 2
  logic [7:0]            shreg;          // Outgoing byte
  logic [7:0]            next_shreg;
  logic                  dout;           // Bit on the wire
  logic                  next_dout;
  logic                  oe4_n;          // Serial out enable
  logic                  next_oe4_n;
  logic                  oe3_n;          // Shared pin enable
  logic                  next_oe3_n;
  logic                  load;           // Load byte at this falling edge

  assign req_edge = req_s2 ^ req_s3;

  // Fetch side next values
  always_comb begin
    next_mode     = three_wire_select;
    next_state    = state;
    next_reg_addr = reg_addr;
    next_hold     = hold;
    unique case (state)
      // Wait for link to ask for a register
      spirp_pkg::ST_IDLE: begin
        if (req_edge) begin
          next_reg_addr = link_addr;
          next_state    = spirp_pkg::ST_FETCH;
        end
      end
      // Capture register file answer
      spirp_pkg::ST_FETCH: begin
        next_hold  = reg_data;
        next_state = spirp_pkg::ST_IDLE;
      end
      // Recover from an illegal code
      default: next_state = spirp_pkg::ST_IDLE;
    endcase
  end

  // Fetch side registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode     <= spirp_pkg::MODE_RST;
      state    <= spirp_pkg::ST_IDLE;
      reg_addr <= spirp_pkg::ADDR_RST;
      hold     <= spirp_pkg::DATA_RST;
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      req_s3   <= 1'b0;
    end else if (ce) begin
      mode     <= next_mode;
      state    <= next_state;
      reg_addr <= next_reg_addr;
      hold     <= next_hold;
      req_s1   <= req;
      req_s2   <= req_s1;
      req_s3   <= req_s2;
    end
  end

  // Mode crosses into the link domain; settles before pulse 16
  always_ff @(posedge sclk) begin
    mode_s1 <= mode;
    mode_s2 <= mode_s1;
  end

  // Link rising edge next values
  always_comb begin
    next_cnt       = (cnt == spirp_pkg::CNT_BYTE_LAST) ? spirp_pkg::CNT_BYTE_FIRST : cnt + 5'h01;
    next_rw        = rw;
    next_link_addr = link_addr;
    next_req       = req;
    if (cnt == spirp_pkg::CNT_IDLE) begin
      next_rw = serial_in_pin;
    end else if (cnt <= spirp_pkg::CNT_ADDR_LAST) begin
      next_link_addr = {link_addr[5:0], serial_in_pin};
    end
    if (cnt == spirp_pkg::CNT_ADDR_LAST && rw) begin
      next_req = ~req;
    end
    // next register every byte
    // Prefetch right after each byte load, so the next byte is ready by its load edge
    if ((cnt == spirp_pkg::CNT_DUMMY_LAST || cnt == spirp_pkg::CNT_BYTE_LAST) && rw) begin
      next_link_addr = link_addr + 7'h01;
      next_req       = ~req;
    end
  end

  // chip select high clears link state
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      cnt       <= spirp_pkg::CNT_IDLE;
      rw        <= 1'b0;
      link_addr <= spirp_pkg::ADDR_RST;
      // Toggle restarts at zero; a possible extra fetch here is harmless
      req       <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      rw        <= next_rw;
      link_addr <= next_link_addr;
      req       <= next_req;
    end
  end

  // drive only inside a read frame
  // Byte load at falling edge of pulse 16 and each byte end
  assign load = rw && (cnt == spirp_pkg::CNT_DUMMY_LAST || cnt == spirp_pkg::CNT_BYTE_LAST);

  // Link falling edge next values
  always_comb begin
    next_shreg = {shreg[6:0], 1'b0};
    next_dout  = shreg[6];
    next_oe4_n = oe4_n;
    next_oe3_n = oe3_n;
    if (load) begin
      next_shreg = hold;
      next_dout  = hold[7];
      // serial out stays off in three-wire
      if (mode_s2) begin
        next_oe3_n = 1'b0;
      end else begin
        next_oe4_n = 1'b0;
      end
    end
  end

  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      shreg <= spirp_pkg::DATA_RST;
      dout  <= 1'b0;
      oe4_n <= 1'b1;
      oe3_n <= 1'b1;
    end else begin
      shreg <= next_shreg;
      dout  <= next_dout;
      oe4_n <= next_oe4_n;
      oe3_n <= next_oe3_n;
    end
  end

  assign serial_out_pin   = dout;
  assign serial_out_oe_n  = oe4_n;
  assign shared_data_out  = dout;
  assign shared_data_oe_n = oe3_n;

  // ---------------- Assertions ----------------
  // Three-wire burst crossing a byte boundary
  property p_sclk_hold_mode;
    @(posedge sclk) disable iff (chip_select_n) (cnt == 5'h18 && rw && mode_s2) ##1 (cnt == 5'h11);
  endproperty

  a_addr_to_file: assert property (@(posedge mclk) disable iff (rst)
    (req_edge && ce && state == spirp_pkg::ST_IDLE) |=> (reg_addr == link_addr && state == spirp_pkg::ST_FETCH))
    else $error("register address not taken from link");
  a_hold_capture: assert property (@(posedge mclk) disable iff (rst)
    (state == spirp_pkg::ST_FETCH && ce) |=> (hold == $past(reg_data) && state == spirp_pkg::ST_IDLE))
    else $error("fetched byte not captured");
  a_mode_reset: assert property (@(posedge mclk) rst |=> !mode)
    else $error("mode not four-wire after reset");
  a_addr_request: assert property (@(posedge sclk) disable iff (chip_select_n)
    (cnt == 5'h07 && rw) |=> (req != $past(req) && cnt == 5'h08))
    else $error("no fetch request after address byte");
  a_burst_incr: assert property (@(posedge sclk) disable iff (chip_select_n)
    (cnt == 5'h18 && rw) |=> (link_addr == $past(link_addr) + 7'h01 && cnt == 5'h11))
    else $error("address not incremented after data byte");
  a_three_wire_msb: assert property (@(posedge sclk) disable iff (chip_select_n)
    (cnt == 5'h10 && rw && mode_s2) |-> (!shared_data_oe_n && shared_data_out == hold[7] && serial_out_oe_n))
    else $error("shared pin not driving first data bit");
  a_four_wire_msb: assert property (@(posedge sclk) disable iff (chip_select_n)
    (cnt == 5'h10 && rw && !mode_s2) |-> (!serial_out_oe_n && serial_out_pin == hold[7] && shared_data_oe_n))
    else $error("serial out not driving first data bit");
  a_miso_off: assert property (@(posedge sclk) disable iff (chip_select_n) mode_s2 |-> serial_out_oe_n)
    else $error("serial out enabled in three-wire mode");
  a_cs_release: assert property (@(posedge mclk) disable iff (rst)
    chip_select_n |-> (serial_out_oe_n && shared_data_oe_n))
    else $error("output driven with chip select high");
  a_no_self_drive: assert property (@(posedge sclk) disable iff (chip_select_n)
    (!rw || cnt < 5'h10) |-> (serial_out_oe_n && shared_data_oe_n))
    else $error("drive without a read frame");
  a_first_prefetch: assert property (@(posedge sclk) disable iff (chip_select_n)
    (cnt == 5'h10 && rw) |=> (link_addr == $past(link_addr) + 7'h01 && req != $past(req)))
    else $error("next register not requested after first load");

  c_four_wire_read: cover property (@(posedge sclk) disable iff (chip_select_n) cnt == 5'h11 && !serial_out_oe_n);
  c_three_wire_read: cover property (@(posedge sclk) disable iff (chip_select_n) cnt == 5'h11 && !shared_data_oe_n);
  c_burst_read: cover property (@(posedge sclk) disable iff (chip_select_n) cnt == 5'h18 && rw ##1 cnt == 5'h11);
  c_mode_held: cover property (p_sclk_hold_mode);

endmodule : spirp_read_port
`default_nettype wire

// ==== sim/spirp_host_model.sv ====
// Host primary model: drives chip select, link clock and data, collects read bytes.
// Assumes a pull-up on every link line and link clock stopped between frames.
`timescale 1ns/1ps
`default_nettype none
module spirp_host_model (
  // Link clock and frame
  output logic      sclk,
  output logic      chip_select_n,
  // Data lines
  output wire       serial_in_pin,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe_n,
  input  wire logic shared_data_out,
  input  wire logic shared_data_oe_n
);
  logic       host_oe;  // Host drives data line
  logic       host_d;   // Host data bit
  logic [7:0] rx [4];   // Received bytes
  int         faults;   // Driver faults seen
  // Shared line, pulled up when released
  assign serial_in_pin = !shared_data_oe_n ? shared_data_out : (host_oe ? host_d : 1'b1);
  initial begin
    {sclk, host_oe, host_d, faults} = '0;
    // Low pulse gives the link logic a clean chip-select reset edge
    chip_select_n = 1'b0;
    #5 chip_select_n = 1'b1;
  end
  // One frame of n clock pulses
  task automatic frame(input logic tw, input logic rd, input logic [6:0] a, input int n);
    logic [15:0] hdr;
    logic        line;
    hdr = {rd, a, 8'hA5};
    chip_select_n = 1'b0;
    #20;
    for (int p = 1; p <= n; p++) begin
      // change after fall, sample on rise
      host_oe = (p <= 16) || !rd;
      host_d  = (p <= 16) ? hdr[16-p] : 1'b0;
      #7.5 sclk = 1'b1;
      line = tw ? serial_in_pin : (!serial_out_oe_n ? serial_out_pin : 1'b1);
      if (rd && p > 16) rx[(p-17)/8][7-(p-17)%8] = line;
      // Driver on only for read data, on the right pin
      if ((tw ? shared_data_oe_n : serial_out_oe_n) !== !(rd && p > 16)) faults++;
      if ((tw ? serial_out_oe_n : shared_data_oe_n) !== 1'b1) faults++;
      #7.5 sclk = 1'b0;
    end
    #10 chip_select_n = 1'b1;
    host_oe = 1'b0;
    #1 if ((serial_out_oe_n & shared_data_oe_n) !== 1'b1) faults++;
    #600;
  endtask : frame
endmodule : spirp_host_model
`default_nettype wire

// ==== sim/spi_register_read_port_test.sv ====
// Bench for the serial read port: table of frames, then reset and partial-frame cases.
// Assumes the host model and a combinational register file here.
`timescale 1ns/1ps
`default_nettype none
module spi_register_read_port_test;
  logic       mclk, rst, ce, three_wire_select;   // System side
  logic [6:0] reg_addr;                           // Register address
  logic [7:0] reg_data;                           // Register data
  wire        sclk, chip_select_n, serial_in_pin; // Link from host
  logic       serial_out_pin, serial_out_oe_n;    // Four-wire out
  logic       shared_data_out, shared_data_oe_n;  // Three-wire out
  int         num_errors, cmp_count;              // Counters
  typedef struct {logic tw; logic rd; logic [6:0] a; int n;} spirp_row_t;
  // Mode, read flag, address, pulses
  spirp_row_t rows [5] = '{'{1'b0,1'b1,7'h05,24}, '{1'b0,1'b1,7'h7E,40}, '{1'b1,1'b1,7'h22,32},
                           '{1'b1,1'b0,7'h10,24}, '{1'b0,1'b0,7'h41,32}};
  // Register file contents
  function automatic logic [7:0] regf(input logic [6:0] a);
    return {a, 1'b0} ^ 8'hC3;
  endfunction : regf
  assign reg_data = regf(reg_addr);
  spirp_read_port spirp_read_port_inst (.mclk(mclk), .rst(rst), .ce(ce),
    .three_wire_select(three_wire_select), .reg_addr(reg_addr), .reg_data(reg_data),
    .sclk(sclk), .chip_select_n(chip_select_n), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
    .shared_data_out(shared_data_out), .shared_data_oe_n(shared_data_oe_n));
  spirp_host_model spirp_host_model_inst (.sclk(sclk), .chip_select_n(chip_select_n),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n), .shared_data_out(shared_data_out),
    .shared_data_oe_n(shared_data_oe_n));
  // Compare one value
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Verdict and end of run
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // Run one frame and check it
  task automatic run(input spirp_row_t r);
    @(posedge mclk) three_wire_select <= r.tw;
    repeat (8) @(posedge mclk);
    spirp_host_model_inst.frame(r.tw, r.rd, r.a, r.n);
    for (int k = 0; k < (r.n - 16) / 8 && r.rd; k++)
      check("rx_byte", regf(7'(r.a + k)), spirp_host_model_inst.rx[k]);
    if (r.rd && r.n % 8 != 0)
      check("rx_part", regf(7'(r.a + (r.n - 16) / 8)) >> (8 - r.n % 8),
            spirp_host_model_inst.rx[(r.n - 16) / 8] >> (8 - r.n % 8));
    check("drive_faults", 8'h00, {7'h00, spirp_host_model_inst.faults != 0});
  endtask : run
  // System clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard
  initial begin
    #300000 num_errors++;
    results();
  end
  // Main sequence
  initial begin
    {num_errors, cmp_count} = '0;
    {rst, ce, three_wire_select} = 3'b110;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 check("reset_addr", {1'b0, spirp_pkg::ADDR_RST}, {1'b0, reg_addr});
    check("reset_oe", 8'h03, {6'h00, serial_out_oe_n, shared_data_oe_n});
    $display("test reset done");
    foreach (rows[i]) begin
      run(rows[i]);
      $display("test row %0d done", i);
    end
    // Read cut off mid-byte, then back-to-back read
    run('{1'b0, 1'b1, 7'h30, 20});
    run('{1'b0, 1'b1, 7'h31, 24});
    $display("test partial done");
    // Reset in mid-run, then a three-wire burst that wraps the address
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 check("reset_addr_mid", {1'b0, spirp_pkg::ADDR_RST}, {1'b0, reg_addr});
    run('{1'b1, 1'b1, 7'h7F, 32});
    $display("test mid reset done");
    results();
  end
endmodule : spi_register_read_port_test
`default_nettype wire
